/* File: common/qsm_pkg.sv */
/*
 * Shared constants for the management serial link: frame layout,
 * register offsets, control register layout, clock timing, host map.
 * Assumes a 100 MHz system clock on both ends.
 */
`default_nettype none
package qsm_pkg;
   // Timing
   localparam int unsigned SYS_CLK_HZ   = 100_000_000;
   localparam int unsigned MDC_MAX_HZ   = 2_500_000;
   localparam int unsigned MDC_HALF_CYC =
      (SYS_CLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ);
   localparam logic [4:0]  MDC_HALF_LAST = 5'(MDC_HALF_CYC - 1);

   // Frame layout
   localparam int          DATA_W       = 16;
   localparam int          ADDR_W       = 5;
   localparam logic [5:0]  PRE_BITS     = 6'h20;
   localparam logic [5:0]  HDR_LAST     = 6'h0c;
   localparam logic [5:0]  DATA_LAST    = 6'h0f;
   localparam logic [1:0]  START_PAT    = 2'h1;
   localparam logic [1:0]  OP_WR        = 2'h1;
   localparam logic [1:0]  OP_RD        = 2'h2;
   localparam logic [1:0]  TA_WR        = 2'h2;
   localparam logic [4:0]  PHY_BCAST    = 5'h00;
   localparam logic [5:0]  IDX_TA       = 6'h2e;
   localparam logic [5:0]  IDX_TA2      = 6'h2f;
   localparam logic [5:0]  IDX_DATA     = 6'h30;
   localparam logic [5:0]  IDX_LAST     = 6'h3f;

   // Device register offsets
   localparam logic [4:0]  REG_CTRL     = 5'h00;
   localparam logic [4:0]  REG_STAT     = 5'h01;
   localparam logic [4:0]  REG_ID_HI    = 5'h02;
   localparam logic [4:0]  REG_ID_LO    = 5'h03;
   localparam logic [4:0]  REG_ADV      = 5'h04;
   localparam logic [4:0]  REG_PARTNER  = 5'h05;
   localparam logic [4:0]  REG_EXPAN    = 5'h06;
   localparam logic [4:0]  REG_NP_TX    = 5'h07;
   localparam logic [4:0]  REG_NP_RX    = 5'h08;
   localparam logic [4:0]  REG_EXT_STAT = 5'h0f;
   localparam logic [4:0]  REG_INT_CTRL = 5'h10;
   localparam logic [4:0]  REG_GEN_CTRL = 5'h12;

   // Control register layout
   localparam int          CTRL_RESET_BIT   = 15;
   localparam int          CTRL_PDOWN_BIT   = 11;
   localparam int          CTRL_RESTART_BIT = 9;
   localparam logic [15:0] CTRL_STORE_MASK  = 16'h5c20;
   localparam logic [15:0] CTRL_FIXED_ONES  = 16'h0140;
   localparam logic [15:0] CTRL_STORE_RST   = 16'h1400;
   localparam logic [15:0] RW_REG_RST       = 16'h0000;

   // Host register map (APB byte addresses)
   localparam logic [7:0]  HOST_CMD      = 8'h00;
   localparam logic [7:0]  HOST_WDATA    = 8'h04;
   localparam logic [7:0]  HOST_RDATA    = 8'h08;
   localparam logic [7:0]  HOST_STATUS   = 8'h0c;
   localparam logic [7:0]  HOST_IRQ_STAT = 8'h10;
   localparam logic [7:0]  HOST_IRQ_EN   = 8'h14;
   localparam logic [7:0]  HOST_IRQ_CLR  = 8'h18;
   localparam int          CMD_GO_BIT    = 0;
   localparam int          CMD_RD_BIT    = 1;
   localparam int          CMD_PHY_LSB   = 2;
   localparam int          CMD_REG_LSB   = 7;
   localparam int          IRQ_DONE_BIT  = 0;
   localparam int          IRQ_NORSP_BIT = 1;
endpackage
`default_nettype wire

/* File: common/qsm_mdio_if.sv */
/*
 * Two-wire management link between host and device.
 * The shared data line is resolved here from both enables, pulled up
 * when nobody drives it.
 */
`default_nettype none
interface qsm_mdio_if;
   logic mdc;
   logic m_out;
   logic m_oe;
   logic s_out;
   logic s_oe;
   logic line;

   assign line = m_oe ? m_out : (s_oe ? s_out : 1'b1);

   modport master (output mdc, m_out, m_oe, input line);
   modport slave  (input mdc, line, output s_out, s_oe);
endinterface
`default_nettype wire

/* File: rtl/qsm_sync3.sv */
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes the input is asynchronous to sys_clk.
 */
`default_nettype none
module qsm_sync3 #(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic sys_clk, // System clock
   input  wire logic rst,     // Async reset, high
   input  wire logic d,       // Asynchronous input
   output var  logic q        // Filtered level
);
   logic s1_r;
   logic s2_r;
   logic s3_r;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
         s3_r <= RST_VAL;
         q    <= RST_VAL;
      end
      else
      begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r)
            q <= s3_r;
      end
   end
endmodule
`default_nettype wire

/* File: rtl/qsm_mgmt_slave.sv */
/*
 * Device end: one channel's management frame decoder and its register
 * bank. Instantiate once per channel; every instance is identical
 * apart from CHANNEL.
 * Assumes the host drives mdc and starts every frame.
 */
`default_nettype none
// Overview of operation
// - Host keeps clock at or below 2.5 MHz
// - Only the host starts frames
// - Addressed device completes every read and write
// - Frame bits move on data line with clock
// - Write opcode stores data word to register
// - Read: device drives turnaround, then data word
// - Physical address is five bits wide
// - Device also answers physical address zero
// - Host side assigns nonzero unique device addresses
// - Register address five bits; upper half vendor
// - Separate data in, out and enable lines
// - Register set repeated identically per channel; power-down sticks only on ch0
// - Unmapped reads return zero, writes ignored
// - Decode control..generic control register map
module qsm_mgmt_slave
   import qsm_pkg::*;
#(
   parameter int          CHANNEL = 0,
   parameter logic [15:0] ID_HIGH = 16'h0a5c, // Arbitrary value
   parameter logic [15:0] ID_LOW  = 16'h1230  // Arbitrary value
) (
   input  wire logic          sys_clk,         // System clock
   input  wire logic          rst,             // Async reset, high
   qsm_mdio_if.slave          mdio,            // Management link
   input  wire logic [4:0]    phy_addr,        // Own physical address
   input  wire logic [15:0]   status_word,     // Status register value
   input  wire logic [15:0]   partner_word,    // Partner ability value
   input  wire logic [15:0]   expansion_word,  // Expansion value
   input  wire logic [15:0]   np_rx_word,      // Next page received
   input  wire logic [15:0]   ext_status_word, // Extended status value
   output var  logic [15:0]   ctrl_word,       // Control register view
   output var  logic [15:0]   adv_word,        // Advertisement
   output var  logic [15:0]   np_tx_word,      // Next page transmit
   output var  logic [15:0]   int_ctrl_word,   // Interrupt control
   output var  logic [15:0]   gen_word,        // Generic control
   output var  logic          soft_reset,      // Module reset pulse
   output var  logic          an_restart,      // Negotiation restart pulse
   output var  logic          power_down       // Low-power request, channel 0 only
);
   typedef enum logic [1:0] {ST_PRE, ST_HDR, ST_TURN, ST_DATA} qsm_slv_state_t;

   qsm_slv_state_t state_r;
   logic [5:0]     cnt_r;
   logic [15:0]    sh_r;
   logic [15:0]    tx_r;
   logic [4:0]     regad_r;
   logic           is_rd_r;
   logic           hit_r;
   logic           oe_r;
   logic           out_r;
   logic           mdc_q;
   logic           mdc_prev_r;
   logic           line_q;
   logic [15:0]    ctrl_r;

   qsm_sync3 #(.RST_VAL(1'b0)) u_sync_mdc (
      .sys_clk (sys_clk),
      .rst     (rst),
      .d       (mdio.mdc),
      .q       (mdc_q)
   );

   qsm_sync3 #(.RST_VAL(1'b1)) u_sync_line (
      .sys_clk (sys_clk),
      .rst     (rst),
      .d       (mdio.line),
      .q       (line_q)
   );

   // Header decode on the last header bit
   wire        rise     = mdc_q & ~mdc_prev_r;
   wire [12:0] hdr      = {sh_r[11:0], line_q};
   wire [1:0]  hdr_op   = hdr[11:10];
   wire [4:0]  hdr_phy  = hdr[9:5];
   wire [4:0]  hdr_reg  = hdr[4:0];
   wire        hdr_ok   = hdr[12] & (hdr_op == OP_RD | hdr_op == OP_WR);
   wire        hdr_hit  = hdr_ok & (hdr_phy == phy_addr | hdr_phy == PHY_BCAST);
   wire        drive_rd = is_rd_r & hit_r;
   wire        pre_full = cnt_r >= PRE_BITS;
   wire        last_hdr = rise & state_r == ST_HDR & cnt_r == HDR_LAST;
   wire        last_dat = rise & state_r == ST_DATA & cnt_r == DATA_LAST;
   wire        wr_en    = last_dat & ~is_rd_r & hit_r;
   wire [15:0] wr_data  = {sh_r[14:0], line_q};

   // Register address decode for the write path; reads decode in read_word
   wire sel_ctrl  = regad_r == REG_CTRL;
   wire sel_adv   = regad_r == REG_ADV;
   wire sel_nptx  = regad_r == REG_NP_TX;
   wire sel_intc  = regad_r == REG_INT_CTRL;
   wire sel_gen   = regad_r == REG_GEN_CTRL;

   function automatic logic [15:0] read_word(input logic [4:0] a);
      logic [15:0] v;
      v = 16'h0000;
      case (a)
         REG_CTRL:     v = ctrl_word;
         REG_STAT:     v = status_word;
         REG_ID_HI:    v = ID_HIGH;
         REG_ID_LO:    v = ID_LOW;
         REG_ADV:      v = adv_word;
         REG_PARTNER:  v = partner_word;
         REG_EXPAN:    v = expansion_word;
         REG_NP_TX:    v = np_tx_word;
         REG_NP_RX:    v = np_rx_word;
         REG_EXT_STAT: v = ext_status_word;
         REG_INT_CTRL: v = int_ctrl_word;
         REG_GEN_CTRL: v = gen_word;
         default:      v = 16'h0000;
      endcase
      return v;
   endfunction

   // Control write: reset restores defaults, power-down sticks on ch0
   wire        ctrl_wr    = wr_en & sel_ctrl;
   wire        pd_sticky  = (CHANNEL == 0) & ctrl_r[CTRL_PDOWN_BIT];
   wire [15:0] ctrl_store = (wr_data & CTRL_STORE_MASK)
                            | ({15'h0000, pd_sticky} << CTRL_PDOWN_BIT);

   assign ctrl_word  = (ctrl_r & CTRL_STORE_MASK) | CTRL_FIXED_ONES;
   assign power_down = pd_sticky;
   assign mdio.s_out = out_r;
   assign mdio.s_oe  = oe_r;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         mdc_prev_r <= 1'b0;
      else
         mdc_prev_r <= mdc_q;
   end

   // Frame engine
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         state_r <= ST_PRE;
         cnt_r   <= 6'h00;
         sh_r    <= 16'h0000;
         tx_r    <= 16'h0000;
         regad_r <= 5'h00;
         is_rd_r <= 1'b0;
         hit_r   <= 1'b0;
         oe_r    <= 1'b0;
         out_r   <= 1'b1;
      end
      else if (rise)
      begin
         case (state_r)
            ST_PRE:
            begin
               if (line_q)
                  cnt_r <= pre_full ? cnt_r : cnt_r + 6'h01;
               else if (pre_full)
               begin
                  state_r <= ST_HDR;
                  cnt_r   <= 6'h00;
               end
               else
                  cnt_r <= 6'h00;
            end
            ST_HDR:
            begin
               sh_r  <= {sh_r[14:0], line_q};
               cnt_r <= cnt_r + 6'h01;
               if (last_hdr)
               begin
                  cnt_r   <= 6'h00;
                  state_r <= hdr_ok ? ST_TURN : ST_PRE;
                  is_rd_r <= hdr_op == OP_RD;
                  hit_r   <= hdr_hit;
                  regad_r <= hdr_reg;
                  tx_r    <= read_word(hdr_reg);
               end
            end
            ST_TURN:
            begin
               cnt_r <= cnt_r + 6'h01;
               if (cnt_r == 6'h00 && drive_rd)
               begin
                  oe_r  <= 1'b1;
                  out_r <= 1'b0;
               end
               if (cnt_r != 6'h00)
               begin
                  state_r <= ST_DATA;
                  cnt_r   <= 6'h00;
                  out_r   <= tx_r[15];
                  tx_r    <= {tx_r[14:0], 1'b0};
               end
            end
            ST_DATA:
            begin
               sh_r  <= {sh_r[14:0], line_q};
               cnt_r <= cnt_r + 6'h01;
               out_r <= tx_r[15];
               tx_r  <= {tx_r[14:0], 1'b0};
               if (last_dat)
               begin
                  state_r <= ST_PRE;
                  cnt_r   <= 6'h00;
                  oe_r    <= 1'b0;
                  out_r   <= 1'b1;
               end
            end
            default:
               state_r <= ST_PRE;
         endcase
      end
   end

   // Register bank, one per channel instance
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_r        <= CTRL_STORE_RST;
         adv_word      <= RW_REG_RST;
         np_tx_word    <= RW_REG_RST;
         int_ctrl_word <= RW_REG_RST;
         gen_word      <= RW_REG_RST;
         soft_reset    <= 1'b0;
         an_restart    <= 1'b0;
      end
      else
      begin
         soft_reset <= ctrl_wr & wr_data[CTRL_RESET_BIT];
         an_restart <= ctrl_wr & wr_data[CTRL_RESTART_BIT];
         if (ctrl_wr)
            ctrl_r <= wr_data[CTRL_RESET_BIT] ? CTRL_STORE_RST : ctrl_store;
         if (wr_en & sel_adv)
            adv_word <= wr_data;
         if (wr_en & sel_nptx)
            np_tx_word <= wr_data;
         if (wr_en & sel_intc)
            int_ctrl_word <= wr_data;
         if (wr_en & sel_gen)
            gen_word <= wr_data;
      end
   end
endmodule
`default_nettype wire

/* File: rtl/qsm_mdio_master.sv */
/*
 * Host end: management frame master ordered over APB, with sticky
 * interrupt status. Makes the link clock by dividing sys_clk.
 * Assumes an APB master on sys_clk.
 */
`default_nettype none
module qsm_mdio_master
   import qsm_pkg::*;
(
   input  wire logic        sys_clk, // System clock
   input  wire logic        rst,     // Async reset, high
   qsm_mdio_if.master       mdio,    // Management link
   input  wire logic [7:0]  paddr,   // APB address
   input  wire logic        psel,    // APB select
   input  wire logic        penable, // APB enable
   input  wire logic        pwrite,  // APB direction
   input  wire logic [31:0] pwdata,  // APB write data
   output var  logic [31:0] prdata,  // APB read data
   output var  logic        pready,  // APB ready
   output var  logic        pslverr, // APB error
   output var  logic        irq      // Interrupt level
);
   logic        busy_r;
   logic        rd_r;
   logic [4:0]  phy_r;
   logic [4:0]  reg_r;
   logic [15:0] wdata_r;
   logic [15:0] rdata_r;
   logic [31:0] frame_r;
   logic [5:0]  idx_r;
   logic [4:0]  div_r;
   logic        mdc_r;
   logic        out_r;
   logic        oe_r;
   logic [1:0]  irq_stat_r;
   logic [1:0]  irq_en_r;
   logic        line_q;

   qsm_sync3 #(.RST_VAL(1'b1)) u_sync_line (
      .sys_clk (sys_clk),
      .rst     (rst),
      .d       (mdio.line),
      .q       (line_q)
   );

   wire        apb_wr   = psel & penable & pwrite;
   wire        apb_rd   = psel & ~penable & ~pwrite;
   wire        go       = apb_wr & paddr == HOST_CMD & pwdata[CMD_GO_BIT] & ~busy_r;
   wire        cmd_rd   = pwdata[CMD_RD_BIT];
   wire [4:0]  cmd_phy  = pwdata[CMD_PHY_LSB +: 5];
   wire [4:0]  cmd_reg  = pwdata[CMD_REG_LSB +: 5];
   wire [1:0]  cmd_op   = cmd_rd ? OP_RD : OP_WR;
   wire [1:0]  cmd_ta   = cmd_rd ? 2'h3 : TA_WR;
   wire [31:0] new_frm  = {START_PAT, cmd_op, cmd_phy, cmd_reg, cmd_ta, wdata_r};
   wire        half     = busy_r & div_r == MDC_HALF_LAST;
   wire        rising   = half & ~mdc_r;
   wire        falling  = half & mdc_r;
   wire [5:0]  idx_nxt  = idx_r + 6'h01;
   wire        finish   = falling & idx_r == IDX_LAST;
   wire        ev_norsp = rising & rd_r & idx_r == IDX_TA2 & line_q;
   wire [1:0]  ev       = {ev_norsp, finish};
   wire [1:0]  clr      = {2{apb_wr & paddr == HOST_IRQ_CLR}} & pwdata[1:0];
   wire [31:0] cmd_view = {20'h00000, reg_r, phy_r, rd_r, busy_r};
   wire [31:0] rd_mux   =
      paddr == HOST_CMD      ? cmd_view :
      paddr == HOST_WDATA    ? {16'h0000, wdata_r} :
      paddr == HOST_RDATA    ? {16'h0000, rdata_r} :
      paddr == HOST_STATUS   ? {31'h00000000, busy_r} :
      paddr == HOST_IRQ_STAT ? {30'h00000000, irq_stat_r} :
      paddr == HOST_IRQ_EN   ? {30'h00000000, irq_en_r} : 32'h00000000;

   assign pready     = 1'b1;
   assign pslverr    = 1'b0;
   assign irq        = |(irq_stat_r & irq_en_r);
   assign mdio.mdc   = mdc_r;
   assign mdio.m_out = out_r;
   assign mdio.m_oe  = oe_r;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         prdata     <= 32'h00000000;
         wdata_r    <= 16'h0000;
         irq_en_r   <= 2'h0;
         irq_stat_r <= 2'h0;
      end
      else
      begin
         if (apb_rd)
            prdata <= rd_mux;
         if (apb_wr & paddr == HOST_WDATA & ~busy_r)
            wdata_r <= pwdata[15:0];
         if (apb_wr & paddr == HOST_IRQ_EN)
            irq_en_r <= pwdata[1:0];
         irq_stat_r <= (irq_stat_r & ~clr) | ev;
      end
   end

   // Frame sequencer: drive after the falling edge, sample at the rising one
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         busy_r  <= 1'b0;
         rd_r    <= 1'b0;
         phy_r   <= 5'h00;
         reg_r   <= 5'h00;
         rdata_r <= 16'h0000;
         frame_r <= 32'h00000000;
         idx_r   <= 6'h00;
         div_r   <= 5'h00;
         mdc_r   <= 1'b0;
         out_r   <= 1'b1;
         oe_r    <= 1'b0;
      end
      else if (go)
      begin
         busy_r  <= 1'b1;
         rd_r    <= cmd_rd;
         phy_r   <= cmd_phy;
         reg_r   <= cmd_reg;
         frame_r <= new_frm;
         idx_r   <= 6'h00;
         div_r   <= 5'h00;
         mdc_r   <= 1'b0;
         out_r   <= 1'b1;
         oe_r    <= 1'b1;
      end
      else if (busy_r)
      begin
         div_r <= half ? 5'h00 : div_r + 5'h01;
         if (rising)
         begin
            mdc_r <= 1'b1;
            if (rd_r && idx_r >= IDX_DATA)
               rdata_r <= {rdata_r[14:0], line_q};
         end
         if (falling)
         begin
            mdc_r <= 1'b0;
            idx_r <= idx_nxt;
            if (finish)
            begin
               busy_r <= 1'b0;
               oe_r   <= 1'b0;
               out_r  <= 1'b1;
            end
            else if (idx_nxt >= PRE_BITS)
            begin
               out_r   <= frame_r[31];
               frame_r <= {frame_r[30:0], 1'b0};
               if (rd_r && idx_nxt >= IDX_TA)
                  oe_r <= 1'b0;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: sim/qsm_link_monitor.sv */
/*
 * Checker of the shared management wire: clock timing, ownership.
 * Assumes it sits beside the link interface, fed by its signals.
 */
`default_nettype none
module qsm_link_monitor
   import qsm_pkg::*;
(
   input wire logic sys_clk, // System clock
   input wire logic rst,     // Async reset, high
   input wire logic mdc,     // Link clock
   input wire logic m_out,   // Host data
   input wire logic m_oe,    // Host enable
   input wire logic s_out,   // Device data
   input wire logic s_oe,    // Device enable
   input wire logic line     // Resolved wire
);
   logic [5:0]  half_r;
   logic [10:0] hi_r;
   logic [9:0]  oe_r;
   logic [9:0]  lo_r;
   logic        go_r;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         half_r <= '0;
         hi_r   <= '0;
         oe_r   <= '0;
         lo_r   <= '0;
         go_r   <= 1'b0;
      end
      else
      begin
         half_r <= $changed(mdc) ? 6'h0 : half_r + 6'(half_r != 6'h3f);
         hi_r   <= (m_oe && m_out) ? hi_r + 11'(hi_r != 11'h7ff) : 11'h0;
         oe_r   <= s_oe ? oe_r + 10'h1 : 10'h0;
         lo_r   <= m_oe ? 10'h0 : lo_r + 10'(lo_r != 10'h3ff);
         go_r   <= m_oe && (go_r || $fell(m_out));
      end
   end

   sequence s_ta_zero;
      s_oe && !s_out;
   endsequence
   sequence s_keep_drive;
      s_oe [*8];
   endsequence

   a_mdc_half_min: assert property ($changed(mdc) |-> half_r >= MDC_HALF_LAST)
      else $error("link clock half period too short");
   a_one_driver: assert property (!(m_oe && s_oe))
      else $error("both ends drive the wire");
   a_bits_on_fall: assert property (m_oe && $past(m_oe) && $changed(m_out) |-> $fell(mdc))
      else $error("host data moved off a falling clock");
   a_ta_handover: assert property ($rose(s_oe) |-> s_ta_zero ##1 s_keep_drive)
      else $error("turnaround not driven low");
   a_read_window: assert property ($fell(s_oe) |-> oe_r inside {[10'd670:10'd690]})
      else $error("device drove for a wrong span");
   a_slave_waits: assert property ($rose(s_oe) |-> lo_r inside {[10'd1:10'd60]})
      else $error("device drove outside a read turnaround");
   a_preamble_len: assert property ($fell(m_out) && m_oe && !go_r |-> hi_r >= 11'd1260)
      else $error("frame start without full preamble");
   a_line_pull: assert property (!m_oe && !s_oe |-> line)
      else $error("released wire not high");
endmodule
`default_nettype wire

/* File: sim/qsm_mgmt_slave_test.sv */
/*
 * Self-checking bench: host end and device end joined by the link.
 * Assumes the host answers APB with no wait and a read result queue.
 */
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
module qsm_mgmt_slave_test
   import qsm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, e, m;
   logic [4:0]  phy_addr;
   logic [15:0] status_word, partner_word, expansion_word, np_rx_word, ext_status_word;
   logic [15:0] gen_word, v, ctrl_word, adv_word, np_tx_word, int_ctrl_word;
   logic [15:0] wv [4];
   logic        soft_reset, an_restart, power_down;
   integer      n_ar = 0, n_sr = 0;
   logic [31:0] exp_q [$];
   logic [31:0] msk_q [$];
   logic [4:0]  tbl [4] = '{REG_ADV, REG_NP_TX, REG_INT_CTRL, REG_GEN_CTRL};
   integer      seed, num_errors = 0, n_compared = 0, cyc = 0;
   int          i;

   qsm_mdio_if link ();
   qsm_mdio_master i_qsm_mdio_master (.sys_clk(sys_clk), .rst(rst), .mdio(link.master),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
   qsm_mgmt_slave i_qsm_mgmt_slave (.sys_clk(sys_clk), .rst(rst), .mdio(link.slave),
      .phy_addr(phy_addr), .status_word(status_word), .partner_word(partner_word),
      .expansion_word(expansion_word), .np_rx_word(np_rx_word),
      .ext_status_word(ext_status_word), .ctrl_word(ctrl_word), .adv_word(adv_word),
      .np_tx_word(np_tx_word), .int_ctrl_word(int_ctrl_word), .gen_word(gen_word),
      .soft_reset(soft_reset), .an_restart(an_restart), .power_down(power_down));
   qsm_link_monitor i_qsm_link_monitor (.sys_clk(sys_clk), .rst(rst), .mdc(link.mdc),
      .m_out(link.m_out), .m_oe(link.m_oe), .s_out(link.s_out), .s_oe(link.s_oe),
      .line(link.line));

   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic end_sim();
      $display("checks %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Note the expected read value, then read
   task automatic rd(input logic [7:0] a, input logic [31:0] ev, input logic [31:0] mv);
      exp_q.push_back(ev);
      msk_q.push_back(mv);
      apb(1'b0, a, 32'h0);
   endtask

   // One frame; nr marks an expected missing answer
   task automatic op(input logic r, input logic [4:0] p, input logic [4:0] g,
                     input logic [15:0] d, input logic nr);
      apb(1'b1, HOST_IRQ_CLR, 32'h3);
      apb(1'b1, HOST_WDATA, {16'h0, d});
      apb(1'b1, HOST_CMD, {20'h0, g, p, r, 1'b1});
      rd(HOST_STATUS, 32'h1, 32'h1);
      // Done is the only enabled source here; the bench timeout bounds the wait
      while (irq !== 1'b1) @(posedge sys_clk);
      rd(HOST_IRQ_STAT, {30'h0, nr, 1'b1}, 32'h3);
      rd(HOST_CMD, {20'h0, g, p, r, 1'b0}, 32'hfff);
      if (r && !nr)
         rd(HOST_RDATA, {16'h0, d}, 32'hffff);
   endtask

   always @(posedge sys_clk)
   begin
      if (psel && penable && pready && !pwrite)
      begin
         e = exp_q.pop_front();
         m = msk_q.pop_front();
         `CHK("prdata", e, prdata & m)
         `CHK("pslverr", 1'b0, pslverr)
      end
   end

   always @(posedge sys_clk)
   begin
      cyc++;
      n_ar = n_ar + an_restart;
      n_sr = n_sr + soft_reset;
      if (cyc == 80000)
      begin
         num_errors++;
         end_sim();
      end
   end

   initial
   begin
      seed = 32'hfd73;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      phy_addr = 5'h09;
      status_word = 16'($random(seed));
      partner_word = 16'($random(seed));
      expansion_word = 16'($random(seed));
      np_rx_word = 16'($random(seed));
      ext_status_word = 16'($random(seed));
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (5) @(posedge sys_clk);
      apb(1'b1, HOST_IRQ_EN, 32'h1);
      op(1'b1, 5'h09, REG_CTRL, CTRL_STORE_RST | CTRL_FIXED_ONES, 1'b0);
      for (i = 0; i < 4; i++)
      begin
         v = 16'($random(seed));
         wv[i] = v;
         op(1'b0, 5'h09, tbl[i], v, 1'b0);
         op(1'b1, i[0] ? PHY_BCAST : 5'h09, tbl[i], v, 1'b0);
      end
      `CHK("gen_word", v, gen_word)
      `CHK("adv_word", wv[0], adv_word)
      `CHK("np_tx_word", wv[1], np_tx_word)
      `CHK("int_ctrl_word", wv[2], int_ctrl_word)
      // Power-down sticks on channel 0 until a module reset
      op(1'b0, 5'h09, REG_CTRL, 16'h0a00, 1'b0);
      `CHK("power_down", 1'b1, power_down)
      op(1'b0, 5'h09, REG_CTRL, 16'h1000, 1'b0);
      op(1'b1, 5'h09, REG_CTRL, 16'h1940, 1'b0);
      op(1'b0, PHY_BCAST, REG_CTRL, 16'h8000, 1'b0);
      `CHK("ctrl_word", CTRL_STORE_RST | CTRL_FIXED_ONES, ctrl_word)
      `CHK("power_down", 1'b0, power_down)
      `CHK("an_restart", 1, n_ar)
      `CHK("soft_reset", 1, n_sr)
      op(1'b1, 5'h09, REG_STAT, status_word, 1'b0);
      op(1'b1, 5'h09, REG_EXT_STAT, ext_status_word, 1'b0);
      op(1'b0, 5'h09, 5'h1f, 16'hffff, 1'b0);
      op(1'b1, 5'h09, 5'h1f, 16'h0, 1'b0);
      op(1'b1, 5'h0a, REG_CTRL, 16'h0, 1'b1);
      `CHK("irq", 1'b1, irq)
      apb(1'b1, HOST_IRQ_EN, 32'h2);
      repeat (2) @(posedge sys_clk);
      `CHK("irq", 1'b1, irq)
      apb(1'b1, HOST_IRQ_EN, 32'h0);
      repeat (2) @(posedge sys_clk);
      `CHK("irq", 1'b0, irq)
      apb(1'b1, HOST_IRQ_EN, 32'h3);
      apb(1'b1, HOST_IRQ_CLR, 32'h3);
      repeat (2) @(posedge sys_clk);
      `CHK("irq", 1'b0, irq)
      rd(HOST_IRQ_STAT, 32'h0, 32'h3);
      rd(8'h1c, 32'h0, 32'hffffffff);
      repeat (2) @(posedge sys_clk);
      end_sim();
   end
endmodule
`default_nettype wire
